/* logic/acq_sequencer.sv */
// Acquisition sequencer for a 16-channel multiplexed 16-bit converter, with APB registers.
// Assumes the converter answers each start with one adc_done pulse, trig_in is synchronous to pclk,
// and a DMA engine takes dma words with dma_ready.
`default_nettype none

`include "acq_defs.svh"

// What this block does
// - Sixteen inputs, one selected at a time.
// - Gain stage feeds sixteen-bit result words.
// - Gain codes select one, two, five, ten.
// - Range and gain set per channel.
// - Sixteen-bit interval count, us or ms base.
// - Four modes: simple, scan, sequence, auto.
// - Simple mode converts list, results readable.
// - Six scan variants, trigger and delay options.
// - Scan mode keeps results, no DMA.
// - Single software scan interrupts after last conversion.
// - Hardware scan starts on chosen input edge.
// - Only trigger edges seen while waiting for a trigger start a scan; edges during a scan are ignored.
// - Sequence mode sends every result by DMA.
// - Sequence counters: interrupt period, repeat stop.
// - Repeat count zero runs until stopped.
// - First delay mode: start to start.
// - Second delay mode: end to start.
// - Auto refresh keeps latest result per channel.
module acq_sequencer (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire acq_pkg::apb_req_t  apb_req,
  output var  acq_pkg::apb_rsp_t  apb_rsp,
  output var  acq_pkg::conv_req_t conv_req,
  input  wire logic               adc_done,
  input  wire logic [15:0]        adc_data,
  input  wire logic               trig_in,
  output var  acq_pkg::dma_word_t dma_word,
  input  wire logic               dma_ready,
  output logic                    irq,
  output logic                    running
);
  import acq_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Picks the tick of the selected time base.
  function automatic logic unit_tick(input logic base_ms, input logic us_t, input logic ms_t);
    unit_tick = base_ms ? ms_t : us_t;
  endfunction

  // Counts a timer down by one on its tick, holding at zero.
  function automatic logic [15:0] count_down(input logic [15:0] v, input logic t);
    count_down = (t && v != 16'h0000) ? v - 16'h0001 : v;
  endfunction

  acq_state_t s;
  acq_state_t n;

  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic       cmd_start;
  logic       cmd_stop;
  logic       edge_seen;
  logic       go_conv;
  logic       begin_list;
  logic       end_list;
  logic       is_hw;
  logic       is_cont;
  logic       is_dly;
  logic [4:0] len_eff;
  logic [3:0] idx;
  logic [3:0] ch;
  logic [7:0] a;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------

  // Computes the bus answer, register writes and sequencer step.
  always_comb begin
    n          = s;
    a          = apb_req.paddr;
    idx        = a[5:2];
    ch         = 4'h0;
    cmd_start  = 1'b0;
    cmd_stop   = 1'b0;
    go_conv    = 1'b0;
    begin_list = 1'b0;
    end_list   = 1'b0;
    n.conv.start = 1'b0;
    n.us_tick  = 1'b0;
    n.ms_tick  = 1'b0;

    // Time base prescalers for microsecond and millisecond ticks.
    if (s.us_cnt == 4'(`ACQ_US_CYCLES - 1)) begin
      n.us_cnt  = 4'h0;
      n.us_tick = 1'b1;
    end else begin
      n.us_cnt = s.us_cnt + 4'h1;
    end
    if (s.us_tick) begin
      if (s.ms_cnt == 10'(`ACQ_MS_US - 1)) begin
        n.ms_cnt  = 10'h000;
        n.ms_tick = 1'b1;
      end else begin
        n.ms_cnt = s.ms_cnt + 10'h001;
      end
    end

    // Interval and delay timers count in their own units.
    n.conv_tmr = count_down(s.conv_tmr, unit_tick(s.conv_base_ms, s.us_tick, s.ms_tick));
    n.dly_tmr  = count_down(s.dly_tmr, unit_tick(s.delay_time_base, s.us_tick, s.ms_tick));

    // Edge detector on the trigger input with selectable polarity.
    n.trig_q  = trig_in;
    edge_seen = s.trig_fall ? (s.trig_q & ~trig_in) : (~s.trig_q & trig_in);

    // Scan variant decode: 0 single sw, 1 single hw, 2 cont sw, 3 cont sw delay, 4 cont hw, 5 cont hw delay.
    is_hw   = (s.variant == 3'h1) || (s.variant == 3'h4) || (s.variant == 3'h5);
    is_cont = (s.variant >= 3'h2);
    is_dly  = (s.variant == 3'h3) || (s.variant == 3'h5);
    len_eff = (s.channel_list_length == 5'h00) ? 5'h01 : s.channel_list_length;

    // APB slave: one wait state, then the answer is registered.
    addr_ok = (a[7:6] != 2'b00) || (a[5:2] <= 4'h7);
    rd_en   = apb_req.psel && apb_req.penable && !s.rsp.pready;
    wr_en   = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite && addr_ok;
    n.rsp.pready  = rd_en;
    n.rsp.pslverr = rd_en && !addr_ok;
    n.rsp.prdata  = 32'h0000_0000;
    if (rd_en && addr_ok && !apb_req.pwrite) begin
      case (a[7:6])
        2'b01: n.rsp.prdata = {28'h0, s.channel_list[idx]};
        2'b10: n.rsp.prdata = {27'h0, s.chcfg[idx]};
        2'b11: n.rsp.prdata = {16'h0, s.result[idx]};
        default: begin
          case (a)
            `ACQ_OFF_CTRL:    n.rsp.prdata = {22'h0, s.delay_time_base, s.delay_mode_select, s.conv_base_ms,
                                              s.trig_fall, s.variant, s.mode};
            `ACQ_OFF_CONV:    n.rsp.prdata = {16'h0, s.conv_time};
            `ACQ_OFF_DELAY:   n.rsp.prdata = {16'h0, s.delay_count};
            `ACQ_OFF_LEN:     n.rsp.prdata = {27'h0, s.channel_list_length};
            `ACQ_OFF_REPEAT:  n.rsp.prdata = {16'h0, s.sequence_repeat_count};
            `ACQ_OFF_PER_IRQ: n.rsp.prdata = {16'h0, s.sequences_per_interrupt};
            `ACQ_OFF_STATUS:  n.rsp.prdata = {s.seq_cnt, 13'h0, s.ready, s.irq, s.running};
            default:          n.rsp.prdata = 32'h0000_0000;
          endcase
        end
      endcase
    end

    // Register writes take effect at the edge where pready is seen high.
    if (wr_en) begin
      case (a[7:6])
        2'b01: n.channel_list[idx] = apb_req.pwdata[3:0];
        2'b10: n.chcfg[idx] = apb_req.pwdata[4:0];
        2'b11: n.result[idx] = s.result[idx];
        default: begin
          case (a)
            `ACQ_OFF_CTRL: begin
              n.mode              = acq_mode_t'(apb_req.pwdata[`ACQ_CTRL_MODE_LSB +: 2]);
              n.variant           = apb_req.pwdata[`ACQ_CTRL_VAR_LSB +: 3];
              n.trig_fall         = apb_req.pwdata[`ACQ_CTRL_TRIG_FALL];
              n.conv_base_ms      = apb_req.pwdata[`ACQ_CTRL_CONV_MS];
              n.delay_mode_select = delay_mode_t'(apb_req.pwdata[`ACQ_CTRL_DMODE_LSB +: 2]);
              n.delay_time_base   = apb_req.pwdata[`ACQ_CTRL_DLY_MS];
            end
            `ACQ_OFF_CMD: begin
              cmd_start = apb_req.pwdata[`ACQ_CMD_START];
              cmd_stop  = apb_req.pwdata[`ACQ_CMD_STOP];
              if (apb_req.pwdata[`ACQ_CMD_ACK]) begin
                n.irq = 1'b0;
              end
            end
            `ACQ_OFF_CONV:    n.conv_time = apb_req.pwdata[15:0];
            `ACQ_OFF_DELAY:   n.delay_count = apb_req.pwdata[15:0];
            `ACQ_OFF_LEN:     n.channel_list_length = apb_req.pwdata[4:0];
            `ACQ_OFF_REPEAT:  n.sequence_repeat_count = apb_req.pwdata[15:0];
            `ACQ_OFF_PER_IRQ: n.sequences_per_interrupt = apb_req.pwdata[15:0];
            default:          n.mode = s.mode;
          endcase
        end
      endcase
    end

    // Sequencer step.
    case (s.st)
      ST_IDLE: begin
        if (cmd_start) begin
          n.running = 1'b1;
          n.ready   = 1'b0;
          n.seq_cnt = 16'h0000;
          n.irq_cnt = 16'h0000;
          if (s.mode == MODE_SCAN && is_hw) begin
            n.st = ST_TRIG;
          end else begin
            begin_list = 1'b1;
          end
        end
      end
      ST_TRIG: begin
        if (edge_seen) begin
          begin_list = 1'b1;
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          n.result[s.conv.channel] = adc_data;
          if (s.mode == MODE_SEQ) begin
            n.dma.valid   = 1'b1;
            n.dma.channel = s.conv.channel;
            n.dma.data    = adc_data;
            n.st          = ST_DMA;
          end else begin
            n.st = ST_GAP;
          end
        end
      end
      ST_DMA: begin
        if (dma_ready) begin
          n.dma.valid = 1'b0;
          n.st        = ST_GAP;
        end
      end
      ST_GAP: begin
        if (s.conv_tmr == 16'h0000) begin
          if ({1'b0, s.slot} + 5'h01 < len_eff) begin
            n.slot  = s.slot + 4'h1;
            go_conv = 1'b1;
          end else begin
            end_list = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        if (s.dly_tmr == 16'h0000) begin
          if (s.mode == MODE_SCAN && is_hw) begin
            n.st = ST_TRIG;
          end else begin
            begin_list = 1'b1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Handling of the end of one pass over the channel list.
    if (end_list) begin
      case (s.mode)
        MODE_SIMPLE: begin
          n.ready   = 1'b1;
          n.irq     = 1'b1;
          n.running = 1'b0;
          n.st      = ST_IDLE;
        end
        MODE_AUTO: begin
          begin_list = 1'b1;
        end
        MODE_SCAN: begin
          n.ready = 1'b1;
          if (!is_cont) begin
            n.irq     = 1'b1;
            n.running = 1'b0;
            n.st      = ST_IDLE;
          end else if (is_dly && s.delay_mode_select != DELAY_OFF) begin
            n.st = ST_DELAY;
          end else if (is_hw) begin
            n.st = ST_TRIG;
          end else begin
            begin_list = 1'b1;
          end
        end
        default: begin
          n.seq_cnt = s.seq_cnt + 16'h0001;
          n.irq_cnt = s.irq_cnt + 16'h0001;
          if (s.irq_cnt + 16'h0001 >= s.sequences_per_interrupt) begin
            n.irq     = 1'b1;
            n.irq_cnt = 16'h0000;
          end
          if (s.sequence_repeat_count != 16'h0000 && s.seq_cnt + 16'h0001 == s.sequence_repeat_count) begin
            n.running = 1'b0;
            n.st      = ST_IDLE;
          end else if (s.delay_mode_select != DELAY_OFF) begin
            n.st = ST_DELAY;
          end else begin
            begin_list = 1'b1;
          end
        end
      endcase
      if (n.st == ST_DELAY && s.delay_mode_select == DELAY_END_TO_START) begin
        n.dly_tmr = s.delay_count;
      end
    end

    // Start of a pass: the start-to-start delay is armed here.
    if (begin_list) begin
      n.slot  = 4'h0;
      go_conv = 1'b1;
      if (s.delay_mode_select == DELAY_START_TO_START) begin
        n.dly_tmr = s.delay_count;
      end
    end

    // Launch of one conversion with that channel's gain and range.
    if (go_conv && !cmd_stop) begin
      ch             = s.channel_list[begin_list ? 4'h0 : n.slot];
      n.st           = ST_CONV;
      n.conv_tmr     = s.conv_time;
      n.conv.start   = 1'b1;
      n.conv.channel = ch;
      n.conv.gain    = s.chcfg[ch][1:0];
      n.conv.range   = s.chcfg[ch][`ACQ_CFG_RANGE_LSB +: 3];
    end

    // Stop command aborts any acquisition at once.
    if (cmd_stop) begin
      n.st        = ST_IDLE;
      n.running   = 1'b0;
      n.dma.valid = 1'b0;
      n.conv.start = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Registers the whole state; reset gives constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st                      <= ST_IDLE;
      s.delay_mode_select       <= DELAY_OFF;
      s.mode                    <= MODE_SIMPLE;
      s.conv_time               <= `ACQ_RST_CONV;
      s.delay_count             <= `ACQ_RST_DELAY;
      s.channel_list_length     <= `ACQ_RST_LEN;
      s.sequence_repeat_count   <= `ACQ_RST_REPEAT;
      s.sequences_per_interrupt <= `ACQ_RST_PER_IRQ;
    end else begin
      s <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // Every output is a field of the state register.
  assign apb_rsp  = s.rsp;
  assign conv_req = s.conv;
  assign dma_word = s.dma;
  assign irq      = s.irq;
  assign running  = s.running;

endmodule : acq_sequencer

`default_nettype wire

/* logic/acq_defs.svh */
// Register offsets, field positions, reset values and timing counts of the acquisition sequencer.
// Assumes a 10 MHz APB clock and byte addresses on an 8-bit APB address.
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ACQ_OFF_CTRL     8'h00
`define ACQ_OFF_CMD      8'h04
`define ACQ_OFF_CONV     8'h08
`define ACQ_OFF_DELAY    8'h0C
`define ACQ_OFF_LEN      8'h10
`define ACQ_OFF_REPEAT   8'h14
`define ACQ_OFF_PER_IRQ  8'h18
`define ACQ_OFF_STATUS   8'h1C
`define ACQ_OFF_LIST     8'h40
`define ACQ_OFF_CHCFG    8'h80
`define ACQ_OFF_RESULT   8'hC0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACQ_CTRL_MODE_LSB   0
`define ACQ_CTRL_VAR_LSB    2
`define ACQ_CTRL_TRIG_FALL  5
`define ACQ_CTRL_CONV_MS    6
`define ACQ_CTRL_DMODE_LSB  7
`define ACQ_CTRL_DLY_MS     9
`define ACQ_CMD_START       0
`define ACQ_CMD_STOP        1
`define ACQ_CMD_ACK         2
`define ACQ_STAT_RUN        0
`define ACQ_STAT_IRQ        1
`define ACQ_STAT_READY      2
`define ACQ_STAT_SEQ_LSB    16
`define ACQ_CFG_RANGE_LSB   2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ACQ_RST_CONV     16'h0005
`define ACQ_RST_DELAY    16'h0000
`define ACQ_RST_LEN      5'h01
`define ACQ_RST_REPEAT   16'h0001
`define ACQ_RST_PER_IRQ  16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACQ_CLK_HZ       10000000
`define ACQ_US_CYCLES    (`ACQ_CLK_HZ / 1000000)
`define ACQ_MS_US        1000
`define ACQ_CHANNELS     16

`endif

/* logic/acq_pkg.sv */
// Types shared by the acquisition sequencer and its bench.
// Assumes acq_defs.svh supplies the numeric constants.
`default_nettype none

package acq_pkg;

  // Acquisition modes.
  typedef enum logic [1:0] {
    MODE_SIMPLE = 2'h0,
    MODE_SCAN   = 2'h1,
    MODE_SEQ    = 2'h2,
    MODE_AUTO   = 2'h3
  } acq_mode_t;

  // Delay modes.
  typedef enum logic [1:0] {
    DELAY_OFF          = 2'h0,
    DELAY_START_TO_START = 2'h1,
    DELAY_END_TO_START = 2'h2
  } delay_mode_t;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_TRIG  = 6'h02,
    ST_CONV  = 6'h04,
    ST_DMA   = 6'h08,
    ST_GAP   = 6'h10,
    ST_DELAY = 6'h20
  } acq_state_e_t;

  // Request to the converter front end.
  typedef struct packed {
    logic       start;
    logic [3:0] channel;
    logic [1:0] gain;
    logic [2:0] range;
  } conv_req_t;

  // Result word offered to the DMA engine.
  typedef struct packed {
    logic        valid;
    logic [3:0]  channel;
    logic [15:0] data;
  } dma_word_t;

  // APB request and answer.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Whole state of the sequencer.
  typedef struct packed {
    acq_state_e_t     st;
    acq_mode_t        mode;
    logic [2:0]       variant;
    logic             trig_fall;
    logic             conv_base_ms;
    delay_mode_t      delay_mode_select;
    logic             delay_time_base;
    logic [15:0]      conv_time;
    logic [15:0]      delay_count;
    logic [4:0]       channel_list_length;
    logic [15:0]      sequence_repeat_count;
    logic [15:0]      sequences_per_interrupt;
    logic [15:0][3:0] channel_list;
    logic [15:0][4:0] chcfg;
    logic [15:0][15:0] result;
    logic             running;
    logic             irq;
    logic             ready;
    logic [15:0]      seq_cnt;
    logic [15:0]      irq_cnt;
    logic [3:0]       slot;
    logic [15:0]      conv_tmr;
    logic [15:0]      dly_tmr;
    logic [3:0]       us_cnt;
    logic [9:0]       ms_cnt;
    logic             us_tick;
    logic             ms_tick;
    logic             trig_q;
    conv_req_t        conv;
    dma_word_t        dma;
    apb_rsp_t         rsp;
  } acq_state_t;

endpackage : acq_pkg

`default_nettype wire

/* testbench/acq_sequencer_asserts.sv */
// Checker of the sequencer's bus, converter and DMA timing.
// Assumes a bind to acq_sequencer and pclk as the only clock.
`default_nettype none
module acq_sequencer_asserts (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire acq_pkg::apb_req_t  apb_req,
  input wire acq_pkg::apb_rsp_t  apb_rsp,
  input wire acq_pkg::conv_req_t conv_req,
  input wire logic               adc_done,
  input wire logic [15:0]        adc_data,
  input wire acq_pkg::dma_word_t dma_word,
  input wire logic               dma_ready
);
  import acq_pkg::*;
  logic [7:0] gap;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counts cycles since the last conversion start, saturating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 8'hFF;
    else if (conv_req.start) gap <= 8'h00;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end
  property p_rdy_once;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready too long");
  property p_one_wait;
    apb_req.psel && $rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wrong wait states");
  property p_err_rdy;
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_zero;
    !apb_rsp.pready |-> apb_rsp.prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("prdata outside answer");
  property p_pulse;
    conv_req.start |=> !conv_req.start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_space;
    conv_req.start |-> gap >= 8'h27;
  endproperty
  a_space: assert property (p_space) else $error("starts too close");
  property p_cfg_hold;
    !conv_req.start |-> $stable({conv_req.channel, conv_req.gain, conv_req.range});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("channel setup moved");
  property p_dma_src;
    $rose(dma_word.valid) |-> $past(adc_done) && dma_word.data == $past(adc_data);
  endproperty
  a_dma_src: assert property (p_dma_src) else $error("DMA word not from result");
  property p_dma_hold;
    dma_word.valid && !dma_ready |=> dma_word.valid && $stable(dma_word.data);
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("DMA word dropped");
  property p_dma_drop;
    dma_word.valid && dma_ready |=> !dma_word.valid;
  endproperty
  a_dma_drop: assert property (p_dma_drop) else $error("DMA word repeated");
endmodule // acq_sequencer_asserts

bind acq_sequencer acq_sequencer_asserts i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .conv_req(conv_req), .adc_done(adc_done), .adc_data(adc_data),
  .dma_word(dma_word), .dma_ready(dma_ready));
`default_nettype wire

/* testbench/acq_far_side.sv */
// Model of the converter front end and of the DMA engine.
// Assumes starts come from the sequencer on pclk.
`default_nettype none
module acq_far_side (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire acq_pkg::conv_req_t conv_req,
  input  wire logic               slow,
  output logic                    adc_done,
  output logic [15:0]             adc_data,
  output logic                    dma_ready
);
  import acq_pkg::*;
  logic [3:0]  wait_cnt;
  logic [11:0] seq;
  logic [7:0]  tick;
  // A start runs a fixed conversion time; each result carries its channel and a count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      seq <= 12'h000;
      tick <= 8'h00;
      adc_done <= 1'b0;
    end else begin
      tick <= tick + 8'h01;
      adc_done <= (wait_cnt == 4'h1);
      if (conv_req.start) wait_cnt <= 4'h7;
      else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h1) seq <= seq + 12'h001;
    end
  end
  // Outside a result the data lines show a changing pattern.
  assign adc_data = adc_done ? {conv_req.channel, seq} : {tick, ~tick};
  // A slow engine takes a word in one cycle out of four.
  assign dma_ready = !slow || (tick[1:0] == 2'h0);
endmodule // acq_far_side
`default_nettype wire

/* testbench/acq_sequencer_bench.sv */
// Self-checking bench of the acquisition sequencer and its far-side model.
// Assumes the checker binds itself to the design; pclk runs at 10 MHz.
`default_nettype none
`include "acq_defs.svh"
module acq_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import acq_pkg::*;
  logic        pclk, presetn, trig_in, slow, adc_done, dma_ready, irq, running;
  logic [15:0] adc_data;
  logic [31:0] q;
  logic        e;
  apb_req_t    req;
  apb_rsp_t    apb_rsp;
  conv_req_t   conv_req;
  dma_word_t   dma_word;
  int          num_errors, samples_checked, cyc, nst, ndma;
  int          tst[$];
  logic [3:0]  dch[$];
  logic [4:0]  seen[16];
  logic [15:0] last[16];
  // Design and far-side model.
  acq_sequencer i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(apb_rsp),
    .conv_req(conv_req), .adc_done(adc_done), .adc_data(adc_data), .trig_in(trig_in),
    .dma_word(dma_word), .dma_ready(dma_ready), .irq(irq), .running(running));
  acq_far_side i_far (.pclk(pclk), .presetn(presetn), .conv_req(conv_req), .slow(slow),
    .adc_done(adc_done), .adc_data(adc_data), .dma_ready(dma_ready));
  // The clock toggles every 50 ns.
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // Records starts, results and DMA words, and cuts a hang short.
  always @(negedge pclk) begin
    cyc++;
    if (conv_req.start === 1'b1) begin
      nst++;
      tst.push_back(cyc);
      seen[conv_req.channel] = {conv_req.range, conv_req.gain};
    end
    if (adc_done === 1'b1) last[conv_req.channel] = adc_data;
    if (dma_word.valid === 1'b1 && dma_ready === 1'b1) begin
      ndma++;
      dch.push_back(dma_word.channel);
    end
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // Compares a seen value with the expected one.
  task automatic chk(input logic [32:0] s, input logic [32:0] x);
    samples_checked++;
    if (s !== x) begin
      num_errors++;
      $display("BAD t=%0t seen %h want %h", $time, s, x);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic end_sim;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer: setup, access, wait for pready, release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(negedge pclk);
    while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge pclk);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Polls the status word until one bit reaches the wanted level.
  task automatic wait_bit(input int b, input logic v);
    do rd(`ACQ_OFF_STATUS);
    while (q[b] !== v);
  endtask
  // Sets one list slot and the setup of its channel.
  task automatic slot(input int i, input logic [3:0] ch, input logic [4:0] cf);
    wr(`ACQ_OFF_LIST + 8'(4 * i), {28'h0, ch});
    wr(`ACQ_OFF_CHCFG + 8'(4 * ch), {27'h0, cf});
  endtask
  // Sets mode and list length, then starts.
  task automatic go(input logic [31:0] ctrl, input logic [31:0] len);
    wr(`ACQ_OFF_CTRL, ctrl);
    wr(`ACQ_OFF_LEN, len);
    wr(`ACQ_OFF_CMD, 32'h1);
  endtask
  // Reset values, a refused offset and a clipped interval.
  task automatic t_regs;
    rd(`ACQ_OFF_REPEAT);
    chk(q, 32'h1);
    rd(`ACQ_OFF_STATUS);
    chk(q, 32'h0);
    rd(8'h20);
    chk({e, q}, 33'h1_0000_0000);
    wr(`ACQ_OFF_CONV, 32'h0003_FFFF);
    rd(`ACQ_OFF_CONV);
    chk(q, 32'h0000_FFFF);
    wr(`ACQ_OFF_CONV, 32'h5);
  endtask
  // Simple mode over two channels, then acknowledge.
  task automatic t_simple;
    slot(0, 4'h3, 5'h16);
    slot(1, 4'hC, 5'h07);
    go(32'h0, 32'h2);
    wait_bit(2, 1'b1);
    rd(`ACQ_OFF_RESULT + 8'h0C);
    chk(q, {16'h0, last[3]});
    rd(`ACQ_OFF_RESULT + 8'h30);
    chk(q, {16'h0, last[12]});
    chk({seen[3], seen[12]}, 10'h2C7);
    chk(irq, 1'b1);
    wr(`ACQ_OFF_CMD, 32'h4);
    rd(`ACQ_OFF_STATUS);
    chk({irq, q[1:0]}, 3'h0);
  endtask
  // Auto refresh with every gain code, stopped, then storage read.
  task automatic t_auto;
    int k;
    for (int i = 0; i < 4; i++) slot(i, 4'(i), 5'(i));
    go(32'h3, 32'h4);
    repeat (600) @(posedge pclk);
    k = nst;
    while (nst == k) @(posedge pclk);
    repeat (10) @(posedge pclk);
    chk(running, 1'b1);
    wr(`ACQ_OFF_CMD, 32'h2);
    for (int i = 0; i < 4; i++) begin
      rd(`ACQ_OFF_RESULT + 8'(4 * i));
      chk(q, {16'h0, last[i]});
      chk(seen[i], 5'(i));
    end
  endtask
  // Three sequences of three channels, interrupt every two, slow DMA.
  task automatic t_seq;
    logic [3:0] tab[3] = '{4'h5, 4'h9, 4'h2};
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) slot(i, tab[i], 5'h00);
    wr(`ACQ_OFF_REPEAT, 32'h3);
    wr(`ACQ_OFF_PER_IRQ, 32'h2);
    ndma = 0;
    go(32'h2, 32'h3);
    wait_bit(1, 1'b1);
    chk(ndma, 6);
    wr(`ACQ_OFF_CMD, 32'h4);
    wait_bit(0, 1'b0);
    chk({q[31:16], 16'(ndma)}, {16'h3, 16'h9});
    for (int i = 0; i < 9; i++) chk(dch[i], tab[i % 3]);
  endtask
  // Repeat count zero runs until stopped.
  task automatic t_forever;
    wr(`ACQ_OFF_REPEAT, 32'h0);
    wr(`ACQ_OFF_PER_IRQ, 32'h1);
    ndma = 0;
    go(32'h2, 32'h1);
    while (ndma < 5) @(posedge pclk);
    rd(`ACQ_OFF_STATUS);
    chk(q[0], 1'b1);
    wr(`ACQ_OFF_CMD, 32'h6);
    rd(`ACQ_OFF_STATUS);
    chk({running, q[0]}, 2'h0);
  endtask
  // Two sequences of one channel; start-to-start gap within bounds.
  task automatic t_delay(input logic [1:0] dm, input logic [15:0] d, input int lo, input int hi);
    int gap;
    wr(`ACQ_OFF_REPEAT, 32'h2);
    wr(`ACQ_OFF_DELAY, {16'h0, d});
    tst.delete();
    go({23'h0, dm, 7'h02}, 32'h1);
    wait_bit(0, 1'b0);
    gap = tst[1] - tst[0];
    chk(gap >= lo && gap <= hi, 1'b1);
  endtask
  // All six scan variants on falling trigger edges.
  task automatic t_scan;
    int k;
    for (int v = 0; v < 6; v++) begin
      k = nst;
      ndma = 0;
      go({26'h0, 1'b1, 3'(v), 2'h1}, 32'h2);
      repeat (100) @(posedge pclk);
      if (v == 1 || v > 3) begin
        chk(nst - k, 0);
        trig_in <= 1'b0;
        repeat (300) @(posedge pclk);
        trig_in <= 1'b1;
      end
      repeat (300) @(posedge pclk);
      rd(`ACQ_OFF_STATUS);
      if (v == 2 || v == 3) chk(nst - k > 4, 1'b1);
      else chk(nst - k, 2);
      if (v < 2) chk(q[1:0], 2'h2);
      chk(ndma, 0);
      wr(`ACQ_OFF_CMD, 32'h6);
      repeat (50) @(posedge pclk);
    end
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    presetn = 1'b0;
    trig_in = 1'b1;
    slow = 1'b0;
    req = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_simple();
    t_auto();
    t_seq();
    t_forever();
    slow <= 1'b0;
    t_delay(2'h1, 16'h0064, 985, 1004);
    t_delay(2'h2, 16'h0014, 229, 253);
    t_scan();
    end_sim();
  end
endmodule // acq_sequencer_bench
`default_nettype wire
